// ### flash_status_pkg.sv
/*
 * Types of the serial flash status register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package flash_status_pkg;
    typedef enum logic [2:0] {ph_opcode, ph_read, ph_wdata, ph_wdone, ph_other} phase_e;
    typedef enum logic [1:0] {op_none, op_prog, op_erase, op_chip} op_kind_e;
endpackage

// ### flash_status_reg.sv
/*
 * Status register one of a serial flash and the command gating around it:
 * serial command decode, status readout, write latch, error flags,
 * block protection and busy tracking.
 * Assumes SPI mode 0 pins sampled by sys_clk_i (far slower SPI clock),
 * and program/erase engines plus address decode on sys_clk_i.
 */
`timescale 1ns/100ps
`include "flash_status_regs.svh"

module flash_status_reg
    import flash_status_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       sck_i,
    input  wire logic       cs_n_i,
    input  wire logic       si_i,
    input  wire logic       wp_n_i,
    output logic            so_o,
    output logic            so_oe_n_o,
    input  wire logic       protect_volatility_select_i,
    input  wire logic       freeze_i,
    input  wire logic       target_locked_i,
    input  wire logic       eng_done_i,
    input  wire logic       eng_fail_i,
    output logic            prog_start_o,
    output logic            erase_start_o,
    output logic            chip_erase_start_o,
    output logic            erase_suspend_o,
    output logic            prog_suspend_o,
    output logic [7:0]      status_o
);

    // pin index: 0 sck, 1 cs_n, 2 si, 3 wp_n
    logic [3:0] sync1_q, sync2_q, prev_q;
    logic       sck_rise, sck_fall, cs_act, cs_end, wp_n_s;

    logic [2:0] bit_q, bit_d;
    logic [1:0] byte_q, byte_d;
    logic [7:0] shin_q, shin_d;
    logic [7:0] opc_q, opc_d;
    logic [7:0] wdata_q, wdata_d;
    logic [7:0] shout_q, shout_d;
    logic       so_q, so_d;
    logic       oe_q, oe_d;
    phase_e     phase_q, phase_d;

    logic       lock_q, lock_d;
    logic       pfail_q, pfail_d;
    logic       efail_q, efail_d;
    logic [2:0] bp_q, bp_d;
    logic [2:0] nv_bp_q, nv_bp_d;
    logic       wel_q, wel_d;
    logic       init_q, init_d;
    op_kind_e   kind_q, kind_d;
    logic [4:0] wrr_cnt_q, wrr_cnt_d;
    logic [7:0] status_q, status_d;
    logic       pstart_q, pstart_d;
    logic       estart_q, estart_d;
    logic       cstart_q, cstart_d;
    logic       esusp_q, esusp_d;
    logic       psusp_q, psusp_d;

    logic       pend, exact8, whole, wr_ok;
    logic [7:0] byte_in;

    assign sck_rise = sync2_q[0] & ~prev_q[0];
    assign sck_fall = ~sync2_q[0] & prev_q[0];
    assign cs_act   = ~sync2_q[1];
    assign cs_end   = sync2_q[1] & ~prev_q[1];
    assign wp_n_s   = sync2_q[3];
    assign byte_in  = {shin_q[6:0], sync2_q[2]};
    assign pend     = status_q[`SR_PEND_BIT];
    assign exact8   = (byte_q == 2'd1) && (bit_q == 3'd0);
    assign whole    = (byte_q != 2'd0) && (bit_q == 3'd0);
    assign wr_ok    = wel_q && !pend;

    always_comb begin
        bit_d     = bit_q;
        byte_d    = byte_q;
        shin_d    = shin_q;
        opc_d     = opc_q;
        wdata_d   = wdata_q;
        shout_d   = shout_q;
        so_d      = so_q;
        oe_d      = oe_q;
        phase_d   = phase_q;
        lock_d    = lock_q;
        pfail_d   = pfail_q;
        efail_d   = efail_q;
        bp_d      = bp_q;
        nv_bp_d   = nv_bp_q;
        wel_d     = wel_q;
        init_d    = 1'b1;
        kind_d    = kind_q;
        wrr_cnt_d = wrr_cnt_q;
        pstart_d  = 1'b0;
        estart_d  = 1'b0;
        cstart_d  = 1'b0;
        esusp_d   = 1'b0;
        psusp_d   = 1'b0;

        // protect bits take their power-on value once out of reset
        if (!init_q) begin
            bp_d = protect_volatility_select_i ? `BP_VOL_DEFAULT : nv_bp_q;
        end

        // serial framing
        if (!cs_act) begin
            bit_d   = 3'd0;
            byte_d  = 2'd0;
            phase_d = ph_opcode;
            oe_d    = 1'b0;
        end else if (sck_rise) begin
            shin_d = byte_in;
            bit_d  = bit_q + 3'd1;
            if (bit_q == 3'd7) begin
                byte_d = (byte_q == 2'd2) ? byte_q : byte_q + 2'd1;
                if (phase_q == ph_opcode) begin
                    opc_d = byte_in;
                    if (byte_in == `CMD_RD_STATUS) begin
                        phase_d = ph_read;
                    end else if (byte_in == `CMD_REG_WRITE) begin
                        phase_d = ph_wdata;
                    end else begin
                        phase_d = ph_other;
                    end
                end else if (phase_q == ph_wdata) begin
                    wdata_d = byte_in;
                    phase_d = ph_wdone;
                end
                // each read byte is a fresh status snapshot
                if (phase_q == ph_read || (phase_q == ph_opcode && byte_in == `CMD_RD_STATUS)) begin
                    shout_d = status_q;
                end
            end
        end else if (sck_fall && phase_q == ph_read) begin
            so_d    = shout_q[7];
            shout_d = {shout_q[6:0], shout_q[7]};
            oe_d    = 1'b1;
        end

        // status register write busy period, run for every accepted write
        if (wrr_cnt_q != 5'd0) begin
            wrr_cnt_d = wrr_cnt_q - 5'd1;
            if (wrr_cnt_q == 5'd1) begin
                wel_d = 1'b0;
            end
        end

        // command execution at frame end
        if (cs_end) begin
            unique case (opc_q)
                `CMD_SET_WEL: if (exact8 && !pend) wel_d = 1'b1;
                `CMD_CLR_WEL: if (exact8 && !pend) wel_d = 1'b0;
                `CMD_CLR_ERR: if (exact8) begin
                    pfail_d = 1'b0;
                    efail_d = 1'b0;
                end
                `CMD_SW_RESET: if (exact8) begin
                    wel_d     = 1'b0;
                    pfail_d   = 1'b0;
                    efail_d   = 1'b0;
                    kind_d    = op_none;
                    wrr_cnt_d = 5'd0;
                    bp_d      = protect_volatility_select_i ? `BP_VOL_DEFAULT : nv_bp_q;
                end
                `CMD_ERASE_SUSP: esusp_d = exact8 && kind_q == op_erase;
                `CMD_PROG_SUSP:  psusp_d = exact8 && kind_q == op_prog;
                `CMD_REG_WRITE: begin
                    // the write latch itself is never written here
                    if (phase_q == ph_wdone && bit_q == 3'd0 && wr_ok && (!lock_q || wp_n_s)) begin
                        lock_d = wdata_q[`SR_LOCK_BIT];
                        if (!freeze_i) begin
                            bp_d = wdata_q[`SR_BP_HI:`SR_BP_LO];
                            if (!protect_volatility_select_i) begin
                                nv_bp_d = wdata_q[`SR_BP_HI:`SR_BP_LO];
                            end
                        end
                        wrr_cnt_d = 5'(`REG_WRITE_CYC);
                    end
                end
                `CMD_PROGRAM: if (whole && wr_ok) begin
                    if (target_locked_i) begin
                        pfail_d = 1'b1;
                    end else begin
                        kind_d   = op_prog;
                        pstart_d = 1'b1;
                    end
                end
                `CMD_SECT_ERASE: if (whole && wr_ok) begin
                    if (target_locked_i) begin
                        efail_d = 1'b1;
                    end else begin
                        kind_d   = op_erase;
                        estart_d = 1'b1;
                    end
                end
                `CMD_CHIP_ERASE: if (exact8 && wr_ok && bp_q == 3'h0) begin
                    kind_d   = op_chip;
                    cstart_d = 1'b1;
                end
                default: ;
            endcase
        end

        // engine completion; a failure set here wins over a same-cycle clear
        if (eng_done_i && kind_q != op_none) begin
            kind_d = op_none;
            if (eng_fail_i) begin
                if (kind_q == op_prog) begin
                    pfail_d = 1'b1;
                end else begin
                    efail_d = 1'b1;
                end
            end else begin
                wel_d = 1'b0;
            end
        end

        status_d = {lock_d, pfail_d, efail_d, bp_d, wel_d,
                    (kind_d != op_none) || (wrr_cnt_d != 5'd0) || pfail_d || efail_d};
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_q   <= 4'hA;
            sync2_q   <= 4'hA;
            prev_q    <= 4'hA;
            bit_q     <= 3'd0;
            byte_q    <= 2'd0;
            shin_q    <= 8'h00;
            opc_q     <= 8'h00;
            wdata_q   <= 8'h00;
            shout_q   <= 8'h00;
            so_q      <= 1'b0;
            oe_q      <= 1'b0;
            phase_q   <= ph_opcode;
            lock_q    <= 1'b0;
            pfail_q   <= 1'b0;
            efail_q   <= 1'b0;
            bp_q      <= `BP_VOL_DEFAULT;
            nv_bp_q   <= `BP_NV_DEFAULT;
            wel_q     <= 1'b0;
            init_q    <= 1'b0;
            kind_q    <= op_none;
            wrr_cnt_q <= 5'd0;
            status_q  <= `SR_RESET;
            pstart_q  <= 1'b0;
            estart_q  <= 1'b0;
            cstart_q  <= 1'b0;
            esusp_q   <= 1'b0;
            psusp_q   <= 1'b0;
        end else begin
            sync1_q   <= {wp_n_i, si_i, cs_n_i, sck_i};
            sync2_q   <= sync1_q;
            prev_q    <= sync2_q;
            bit_q     <= bit_d;
            byte_q    <= byte_d;
            shin_q    <= shin_d;
            opc_q     <= opc_d;
            wdata_q   <= wdata_d;
            shout_q   <= shout_d;
            so_q      <= so_d;
            oe_q      <= oe_d;
            phase_q   <= phase_d;
            lock_q    <= lock_d;
            pfail_q   <= pfail_d;
            efail_q   <= efail_d;
            bp_q      <= bp_d;
            nv_bp_q   <= nv_bp_d;
            wel_q     <= wel_d;
            init_q    <= init_d;
            kind_q    <= kind_d;
            wrr_cnt_q <= wrr_cnt_d;
            status_q  <= status_d;
            pstart_q  <= pstart_d;
            estart_q  <= estart_d;
            cstart_q  <= cstart_d;
            esusp_q   <= esusp_d;
            psusp_q   <= psusp_d;
        end
    end

    assign so_o               = so_q;
    assign so_oe_n_o          = ~oe_q;
    assign status_o           = status_q;
    assign prog_start_o       = pstart_q;
    assign erase_start_o      = estart_q;
    assign chip_erase_start_o = cstart_q;
    assign erase_suspend_o    = esusp_q;
    assign prog_suspend_o     = psusp_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_wel_set;
        cs_end && opc_q == `CMD_SET_WEL && exact8 && !pend |=> wel_q && status_q[`SR_WEL_BIT];
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("set latch command lost");

    property p_lock_hold;
        cs_end && opc_q == `CMD_REG_WRITE && lock_q && !wp_n_s |=> $stable(lock_q) && $stable(bp_q);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked register changed");

    property p_wrr_ok;
        cs_end && opc_q == `CMD_REG_WRITE && phase_q == ph_wdone && bit_q == 3'd0 && wr_ok && wp_n_s
        |=> lock_q == $past(wdata_q[`SR_LOCK_BIT]) && status_q[`SR_PEND_BIT] ##16 !status_q[`SR_PEND_BIT];
    endproperty
    a_wrr_ok: assert property (p_wrr_ok) else $error("register write not applied");

    property p_pfail_protect;
        cs_end && opc_q == `CMD_PROGRAM && whole && wr_ok && target_locked_i |=> pfail_q && !prog_start_o;
    endproperty
    a_pfail_protect: assert property (p_pfail_protect) else $error("protected program not flagged");

    property p_flag_clear;
        $fell(pfail_q) || $fell(efail_q)
        |-> $past(cs_end) && ($past(opc_q) == `CMD_CLR_ERR || $past(opc_q) == `CMD_SW_RESET);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("fail flag cleared without command");

    property p_chip_bp;
        chip_erase_start_o |-> $past(bp_q) == 3'h0;
    endproperty
    a_chip_bp: assert property (p_chip_bp) else $error("chip erase with protection set");

    property p_wel_gate;
        prog_start_o || erase_start_o || chip_erase_start_o |-> $past(wel_q) && !$past(pend);
    endproperty
    a_wel_gate: assert property (p_wel_gate) else $error("operation without latch or while busy");

    property p_err_busy;
        $rose(pfail_q | efail_q) ##1 !(cs_end && (opc_q == `CMD_CLR_ERR || opc_q == `CMD_SW_RESET)) [*3]
        |-> status_q[`SR_PEND_BIT];
    endproperty
    a_err_busy: assert property (p_err_busy) else $error("busy dropped with error set");

    property p_wel_done;
        eng_done_i && !eng_fail_i && kind_q != op_none |=> !wel_q;
    endproperty
    a_wel_done: assert property (p_wel_done) else $error("latch kept after success");

    property p_susp;
        erase_suspend_o || prog_suspend_o
        |-> (erase_suspend_o ? $past(kind_q) == op_erase : $past(kind_q) == op_prog);
    endproperty
    a_susp: assert property (p_susp) else $error("suspend without matching operation");

    property p_init_bp;
        $rose(init_q) |-> bp_q == ($past(protect_volatility_select_i) ? `BP_VOL_DEFAULT : $past(nv_bp_q));
    endproperty
    a_init_bp: assert property (p_init_bp) else $error("protect bits wrong after reset");

    c_read: cover property (sck_fall && phase_q == ph_read ##1 !so_oe_n_o);
    c_wrr: cover property (wrr_cnt_q == 5'(`REG_WRITE_CYC));
    c_prog_fail: cover property (eng_done_i && eng_fail_i && kind_q == op_prog);
    c_chip: cover property (chip_erase_start_o);

endmodule

// ### flash_status_regs.svh
/*
 * Command codes, status bit positions, reset values and timing counts
 * of the serial flash status register block.
 * Assumes a 50 ns system clock; included by bare name.
 */
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH

`define CMD_RD_STATUS   8'h05
`define CMD_REG_WRITE   8'h01
`define CMD_SET_WEL     8'h06
`define CMD_CLR_WEL     8'h04
`define CMD_CLR_ERR     8'h30
`define CMD_PROGRAM     8'h02
`define CMD_SECT_ERASE  8'hD8
`define CMD_CHIP_ERASE  8'h60
`define CMD_ERASE_SUSP  8'h75
`define CMD_PROG_SUSP   8'h85
`define CMD_SW_RESET    8'hF0

`define SR_LOCK_BIT     7
`define SR_PFAIL_BIT    6
`define SR_EFAIL_BIT    5
`define SR_BP_HI        4
`define SR_BP_LO        2
`define SR_WEL_BIT      1
`define SR_PEND_BIT     0

`define SR_RESET        8'h00
`define BP_VOL_DEFAULT  3'h7
`define BP_NV_DEFAULT   3'h0

`define SYS_CLK_NS      50
`define REG_WRITE_NS    800
`define REG_WRITE_CYC   ((`REG_WRITE_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

// ### spi_host_model.sv
/*
 * Behavioural mode-0 SPI host that sends command frames to the flash status block.
 * Assumes sys_clk_i is the block clock; sck runs only inside frames.
 */
`timescale 1ns/100ps
module spi_host_model (
    input  wire logic sys_clk_i,
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i,
    input  wire logic so_oe_n_i
);
    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // n bits of d msb first; bits after the first byte are read back
    task automatic frame(input logic [23:0] d, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge sys_clk_i);
        cs_n_o <= 1'b0;
        tick(3);
        for (int k = 0; k < n; k++) begin
            si_o <= d[n-1-k];
            tick(4);
            sck_o <= 1'b1;
            tick(4);
            if (k >= 8) begin
                rd = {rd[6:0], (so_oe_n_i === 1'b0) ? so_i : 1'bx};
            end
            sck_o <= 1'b0;
        end
        tick(4);
        cs_n_o <= 1'b1;
        // released line no longer shows the last bit
        si_o   <= ~si_o;
        tick(6);
    endtask
endmodule

// ### testbench.sv
/*
 * Self-checking bench of the flash status register block.
 * Assumes the spi_host_model partner and a 20 MHz system clock.
 */
`timescale 1ns/100ps
module testbench;
    typedef struct {
        logic [23:0] d;
        int          n;
        logic        wp;
        logic [7:0]  e0;
        logic [7:0]  e1;
    } row_s;

    logic       sys_clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       wp_n      = 1'b1;
    logic       pvs       = 1'b0;
    logic       freeze    = 1'b0;
    logic       locked    = 1'b0;
    logic       done      = 1'b0;
    logic       fail      = 1'b0;
    logic       sck, cs_n, si, so, so_oe_n;
    logic       p_st, e_st, c_st, e_sus, p_sus;
    logic [7:0] status;
    logic [7:0] rd;
    int         err_total = 0;
    int         n_tests   = 0;
    int         n_prog = 0, n_erase = 0, n_chip = 0, n_esus = 0, n_psus = 0;

    row_s rows [16] = '{
        '{24'h000006, 8,  1'b1, 8'h02, 8'h02},
        '{24'h000004, 8,  1'b1, 8'h00, 8'h00},
        '{24'h000003, 7,  1'b1, 8'h00, 8'h00},
        '{24'h00019C, 16, 1'b1, 8'h00, 8'h00},
        '{24'h000006, 8,  1'b1, 8'h02, 8'h02},
        '{24'h0001FF, 16, 1'b1, 8'h9F, 8'h9C},
        '{24'h000006, 8,  1'b1, 8'h9E, 8'h9E},
        '{24'h000100, 16, 1'b0, 8'h9E, 8'h9E},
        '{24'h000100, 16, 1'b1, 8'h03, 8'h00},
        '{24'h000006, 8,  1'b0, 8'h02, 8'h02},
        '{24'h00011C, 16, 1'b0, 8'h1F, 8'h1C},
        '{24'h000006, 8,  1'b1, 8'h1E, 8'h1E},
        '{24'h000060, 8,  1'b1, 8'h1E, 8'h1E},
        '{24'h010055, 24, 1'b1, 8'h03, 8'h00},
        '{24'h000006, 8,  1'b1, 8'h02, 8'h02},
        '{24'h000060, 8,  1'b1, 8'h03, 8'h03}
    };

    always #25 sys_clk_i = ~sys_clk_i;

    flash_status_reg u_flash_status_reg (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .wp_n_i(wp_n), .so_o(so), .so_oe_n_o(so_oe_n), .protect_volatility_select_i(pvs),
        .freeze_i(freeze), .target_locked_i(locked), .eng_done_i(done), .eng_fail_i(fail),
        .prog_start_o(p_st), .erase_start_o(e_st), .chip_erase_start_o(c_st),
        .erase_suspend_o(e_sus), .prog_suspend_o(p_sus), .status_o(status)
    );

    spi_host_model u_spi_host_model (
        .sys_clk_i(sys_clk_i), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_n_i(so_oe_n)
    );

    always @(posedge sys_clk_i) begin
        if (p_st === 1'b1) n_prog++;
        if (e_st === 1'b1) n_erase++;
        if (c_st === 1'b1) n_chip++;
        if (e_sus === 1'b1) n_esus++;
        if (p_sus === 1'b1) n_psus++;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [23:0] d, input int n, input logic [7:0] e);
        u_spi_host_model.frame(d, n, rd);
        chk(status, e);
    endtask

    // one-cycle engine completion, status checked a few cycles later
    task automatic eng(input logic f, input logic [7:0] e);
        @(posedge sys_clk_i);
        done <= 1'b1;
        fail <= f;
        @(posedge sys_clk_i);
        done <= 1'b0;
        fail <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        chk(status, e);
    endtask

    task automatic note(input string s);
        $display("test %s done, mismatches so far %0d", s, err_total);
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk_i);
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        repeat (4) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        chk(status, 8'h00);
        foreach (rows[i]) begin
            @(posedge sys_clk_i);
            wp_n <= rows[i].wp;
            u_spi_host_model.frame(rows[i].d, rows[i].n, rd);
            chk(status, rows[i].e0);
            repeat (20) @(posedge sys_clk_i);
            chk(status, rows[i].e1);
        end
        chk(8'(n_chip), 8'h01);
        note("table");
        cmd(24'h000004, 8, 8'h03);
        u_spi_host_model.frame(24'h000500, 16, rd);
        chk(rd, 8'h03);
        chk({7'h00, so_oe_n}, 8'h01);
        eng(1'b1, 8'h23);
        repeat (20) @(posedge sys_clk_i);
        chk(status, 8'h23);
        cmd(24'h000030, 8, 8'h02);
        cmd(24'h000004, 8, 8'h00);
        note("busy and clear");
        cmd(24'h000006, 8, 8'h02);
        locked <= 1'b1;
        cmd(24'hD80000, 24, 8'h23);
        cmd(24'h000030, 8, 8'h02);
        locked <= 1'b0;
        cmd(24'hD80000, 24, 8'h03);
        cmd(24'h000085, 8, 8'h03);
        cmd(24'h000075, 8, 8'h03);
        chk(8'({n_erase[3:0], n_esus[1:0], n_psus[1:0]}), 8'h14);
        eng(1'b0, 8'h00);
        note("sector erase");
        cmd(24'h000006, 8, 8'h02);
        locked <= 1'b1;
        cmd(24'h020000, 24, 8'h43);
        cmd(24'h000030, 8, 8'h02);
        locked <= 1'b0;
        cmd(24'h020000, 24, 8'h03);
        cmd(24'h000085, 8, 8'h03);
        eng(1'b1, 8'h43);
        cmd(24'h000030, 8, 8'h02);
        cmd(24'h000004, 8, 8'h00);
        chk(8'({n_prog[3:0], n_psus[3:0]}), 8'h11);
        note("program");
        cmd(24'h000006, 8, 8'h02);
        locked <= 1'b1;
        cmd(24'h000060, 8, 8'h03);
        eng(1'b0, 8'h00);
        locked <= 1'b0;
        note("chip erase");
        @(posedge sys_clk_i);
        pvs       <= 1'b1;
        freeze    <= 1'b1;
        reset_n_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        chk({status[7:1], so_oe_n}, 8'h01);
        chk({3'h0, p_st, e_st, c_st, e_sus, p_sus}, 8'h00);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        chk(status, 8'h1C);
        cmd(24'h000006, 8, 8'h1E);
        cmd(24'h000180, 16, 8'h9F);
        repeat (20) @(posedge sys_clk_i);
        chk(status, 8'h9C);
        cmd(24'h000006, 8, 8'h9E);
        cmd(24'h0000F0, 8, 8'h9C);
        note("volatile protect and freeze");
        finish_test();
    end
endmodule
